/* verilog/dcis_pkg.sv */
// package: constants, map codes and states of the decoder serial control port
// Summary of operation
// - main address bit 1 follows address-select pin: 0x40/0x41 low, 0x42/0x43 high
// - bit 0 of the first byte: 1 master reads, 0 master writes
// - data falling while clock high is a start condition
// - after start shift in 7-bit address then direction, msb first
// - on own address, pull data line low during the ninth clock pulse
// - on foreign address release the line and wait idle for a start
// - first byte is device address, second byte is starting subaddress
// - subaddress advances by one after every data byte written or read, except at the highest subaddress
// - stop at any point returns the port to idle at once; start at any point restarts the address phase
// - invalid subaddress is not acknowledged and port returns to idle
// - read past highest subaddress keeps returning highest register until no acknowledge
// - write past highest subaddress drops the byte, no acknowledge, back to idle
// - any single register is reachable by addressing its subaddress directly
// - main register 0x0E bits 6:5 steer to user, interrupt/vbi or second user map
// - after reset the selector is 00, user sub map selected
// - postproc map answers at register 0xFD bits 7:1; unreachable while zero
// - postproc map access ignores address-select pin and the selector
package dcis_pkg;
    localparam logic [6:0] MAIN_ADDR_BASE = 7'h20;
    localparam logic [6:0] PP_ADDR_OFF    = 7'h00;
    localparam logic [7:0] SUBMAP_REG     = 8'h0E;
    localparam int         SEL_LSB        = 5;
    localparam int         SEL_MSB        = 6;
    localparam logic [7:0] PP_ADDR_REG    = 8'hFD;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] CNT_ZERO       = 4'h0;
    localparam logic [7:0] TOP_USER       = 8'hFF;
    localparam logic [7:0] TOP_INTVBI     = 8'h9F;
    localparam logic [7:0] TOP_USER2      = 8'hEF;
    localparam logic [7:0] TOP_PP         = 8'h7F;

    typedef enum logic [1:0] {
        MAP_USER   = 2'h0,
        MAP_INTVBI = 2'h1,
        MAP_USER2  = 2'h2,
        MAP_PP     = 2'h3
    } dcis_map_t;

    // gray along idle, address, ack, subaddress, ack, data, ack
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV  = 4'h1,
        ST_DACK = 4'h3,
        ST_SUB  = 4'h2,
        ST_SACK = 4'h6,
        ST_WDAT = 4'h7,
        ST_WACK = 4'h5,
        ST_RDAT = 4'hB,
        ST_RACK = 4'hA
    } dcis_state_t;

    function automatic logic [7:0] dcis_top_of(input dcis_map_t m);
        case (m)
            MAP_USER:   dcis_top_of = TOP_USER;
            MAP_INTVBI: dcis_top_of = TOP_INTVBI;
            MAP_USER2:  dcis_top_of = TOP_USER2;
            default:    dcis_top_of = TOP_PP;
        endcase
    endfunction
endpackage

/* verilog/dcis_reg_if.sv */
// interface: register access between the protocol engine and the register store
`timescale 1ns/1ps
`default_nettype none
interface dcis_reg_if;
    import dcis_pkg::*;
    logic       wr_en;
    dcis_map_t  map;
    logic [7:0] sub;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] sel;
    logic [6:0] pp_addr;
    modport ctrl (output wr_en, map, sub, wdata, input rdata, sel, pp_addr);
    modport regs (input wr_en, map, sub, wdata, output rdata, sel, pp_addr);
endinterface
`default_nettype wire

/* verilog/dcis_line_sync.sv */
// module: pin synchronisers and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none
module dcis_line_sync (
    input  wire logic clk,        // system clock
    input  wire logic rst_n,      // synchronous reset, active low
    input  wire logic scl_pin,    // raw serial clock
    input  wire logic sda_pin,    // raw serial data
    input  wire logic asel_pin,   // raw address-select level
    output logic      sda,        // synchronised data level
    output logic      asel,       // synchronised address-select level
    output logic      scl_rise,   // one-cycle pulse, clock rose
    output logic      scl_fall,   // one-cycle pulse, clock fell
    output logic      start_cond, // one-cycle pulse, start seen
    output logic      stop_cond   // one-cycle pulse, stop seen
);
    logic [1:0] scl_m, sda_m, asel_m;
    logic       scl_q, sda_q;

    // first stage only feeds the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_m  <= 2'h3;
            sda_m  <= 2'h3;
            asel_m <= 2'h0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            scl_m  <= {scl_m[0], scl_pin};
            sda_m  <= {sda_m[0], sda_pin};
            asel_m <= {asel_m[0], asel_pin};
            scl_q  <= scl_m[1];
            sda_q  <= sda_m[1];
        end
    end

    assign sda        = sda_m[1];
    assign asel       = asel_m[1];
    assign scl_rise   = scl_m[1] & ~scl_q;
    assign scl_fall   = ~scl_m[1] & scl_q;
    assign start_cond = scl_m[1] & scl_q & sda_q & ~sda_m[1];
    assign stop_cond  = scl_m[1] & scl_q & ~sda_q & sda_m[1];
endmodule
`default_nettype wire

/* verilog/dcis_regstore.sv */
// module: sub map storage, sub map selector and postproc address register
`timescale 1ns/1ps
`default_nettype none
module dcis_regstore (
    input  wire logic clk,   // system clock
    input  wire logic rst_n, // synchronous reset, active low
    dcis_reg_if.regs  rif    // access from the protocol engine
);
    import dcis_pkg::*;
    // storage only, no reset: contents are undefined until written
    logic [7:0] mem [0:3][0:255];
    logic [7:0] selreg_r, selreg_nxt;
    logic [7:0] ppreg_r, ppreg_nxt;
    logic       main_map;

    // the selector register is seen from every main sub map
    assign main_map = (rif.map != MAP_PP);

    always_comb begin
        selreg_nxt = selreg_r;
        ppreg_nxt  = ppreg_r;
        if (rif.wr_en && main_map && rif.sub == SUBMAP_REG) begin
            selreg_nxt = rif.wdata;
        end
        if (rif.wr_en && rif.map == MAP_USER && rif.sub == PP_ADDR_REG) begin
            ppreg_nxt = rif.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            selreg_r <= REG_RESET;
            ppreg_r  <= REG_RESET;
        end else begin
            selreg_r <= selreg_nxt;
            ppreg_r  <= ppreg_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rif.wr_en) begin
            mem[rif.map][rif.sub] <= rif.wdata;
        end
    end

    always_comb begin
        if (main_map && rif.sub == SUBMAP_REG) begin
            rif.rdata = selreg_r;
        end else if (rif.map == MAP_USER && rif.sub == PP_ADDR_REG) begin
            rif.rdata = ppreg_r;
        end else begin
            rif.rdata = mem[rif.map][rif.sub];
        end
    end

    assign rif.sel     = selreg_r[SEL_MSB:SEL_LSB];
    assign rif.pp_addr = ppreg_r[7:1];
endmodule
`default_nettype wire

/* verilog/dcis_i2c_slave.sv */
// module: serial control port slave of the video decoder with map selection
`timescale 1ns/1ps
`default_nettype none
module dcis_i2c_slave (
    input  wire logic              SYS_CLK,               // system clock, 100 MHz
    input  wire logic              RST_N,                 // synchronous reset, active low
    input  wire logic              SERIAL_CLOCK_LINE,     // serial clock from the master
    input  wire logic              SERIAL_DATA_LINE_I,    // level seen on the data line
    output logic                   SERIAL_DATA_LINE_O,    // level driven, always low
    output logic                   SERIAL_DATA_LINE_OE_N, // low while the port pulls low
    input  wire logic              ADDRESS_SELECT_PIN,    // main address bit 1
    output dcis_pkg::dcis_map_t    SUB_MAP_SELECTOR,      // map of the current access
    output logic                   BUSY                   // port out of idle, from any start until released
);
    import dcis_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // line conditioning and register store

    logic sda;
    logic asel;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    dcis_reg_if rif ();

    dcis_line_sync u_sync (
        .clk        (SYS_CLK),
        .rst_n      (RST_N),
        .scl_pin    (SERIAL_CLOCK_LINE),
        .sda_pin    (SERIAL_DATA_LINE_I),
        .asel_pin   (ADDRESS_SELECT_PIN),
        .sda        (sda),
        .asel       (asel),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_cond (start_cond),
        .stop_cond  (stop_cond)
    );

    dcis_regstore u_regs (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .rif   (rif.regs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // protocol state

    dcis_state_t state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic [7:0]  sub_r, sub_nxt;
    dcis_map_t   map_r, map_nxt;
    logic        rw_r, rw_nxt;
    logic        ovf_r, ovf_nxt;
    logic        drive_r, drive_nxt;
    logic        mack_r, mack_nxt;
    logic        wr_r, wr_nxt;
    logic [7:0]  wdata_r, wdata_nxt;

    logic [6:0]  main_addr;
    logic        main_hit;
    logic        pp_hit;
    logic        byte_end;
    logic [7:0]  top;
    dcis_map_t   sel_map;

    assign main_addr = {MAIN_ADDR_BASE[6:1], asel};
    assign main_hit  = (shift_r[7:1] == main_addr);
    // zero field keeps the postproc map shut
    assign pp_hit    = (rif.pp_addr != PP_ADDR_OFF)
                     && (shift_r[7:1] == rif.pp_addr);
    assign byte_end  = scl_fall && (cnt_r == BITS_PER_BYTE);
    assign top       = dcis_top_of(map_r);
    // unused selector code 11 falls back to the user map
    assign sel_map   = (rif.sel == 2'h3) ? MAP_USER : dcis_map_t'(rif.sel);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        sub_nxt   = sub_r;
        map_nxt   = map_r;
        rw_nxt    = rw_r;
        ovf_nxt   = ovf_r;
        drive_nxt = drive_r;
        mack_nxt  = mack_r;
        wr_nxt    = 1'b0;
        wdata_nxt = wdata_r;
        if (stop_cond) begin
            state_nxt = ST_IDLE;
            drive_nxt = 1'b0;
        end else if (start_cond) begin
            // repeated start keeps the subaddress for a combined read
            state_nxt = ST_DEV;
            cnt_nxt   = CNT_ZERO;
            drive_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    drive_nxt = 1'b0;
                end
                ST_DEV, ST_SUB, ST_WDAT: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (byte_end) begin
                        cnt_nxt = CNT_ZERO;
                        case (state_r)
                            ST_DEV: begin
                                if (main_hit || pp_hit) begin
                                    state_nxt = ST_DACK;
                                    drive_nxt = 1'b1;
                                    rw_nxt    = shift_r[0];
                                    map_nxt   = main_hit ? sel_map : MAP_PP;
                                end else begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                            ST_SUB: begin
                                if (shift_r <= top) begin
                                    state_nxt = ST_SACK;
                                    drive_nxt = 1'b1;
                                    sub_nxt   = shift_r;
                                    ovf_nxt   = 1'b0;
                                end else begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                            default: begin
                                if (!ovf_r) begin
                                    state_nxt = ST_WACK;
                                    drive_nxt = 1'b1;
                                    wr_nxt    = 1'b1;
                                    wdata_nxt = shift_r;
                                end else begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                        endcase
                    end
                end
                ST_DACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            state_nxt = ST_RDAT;
                            shift_nxt = rif.rdata;
                            drive_nxt = ~rif.rdata[7];
                        end else begin
                            state_nxt = ST_SUB;
                            drive_nxt = 1'b0;
                        end
                    end
                end
                ST_SACK: begin
                    if (scl_fall) begin
                        state_nxt = ST_WDAT;
                        drive_nxt = 1'b0;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        state_nxt = ST_WDAT;
                        drive_nxt = 1'b0;
                        if (sub_r == top) begin
                            ovf_nxt = 1'b1;
                        end else begin
                            sub_nxt = sub_r + 8'h01;
                        end
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (byte_end) begin
                        state_nxt = ST_RACK;
                        cnt_nxt   = CNT_ZERO;
                        drive_nxt = 1'b0;
                        if (sub_r != top) begin
                            sub_nxt = sub_r + 8'h01;
                        end
                    end else if (scl_fall) begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        drive_nxt = ~shift_r[6];
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            state_nxt = ST_RDAT;
                            shift_nxt = rif.rdata;
                            drive_nxt = ~rif.rdata[7];
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            shift_r <= REG_RESET;
            sub_r   <= REG_RESET;
            map_r   <= MAP_USER;
            rw_r    <= 1'b0;
            ovf_r   <= 1'b0;
            drive_r <= 1'b0;
            mack_r  <= 1'b0;
            wr_r    <= 1'b0;
            wdata_r <= REG_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            sub_r   <= sub_nxt;
            map_r   <= map_nxt;
            rw_r    <= rw_nxt;
            ovf_r   <= ovf_nxt;
            drive_r <= drive_nxt;
            mack_r  <= mack_nxt;
            wr_r    <= wr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rif.wr_en = wr_r;
    assign rif.map   = map_r;
    assign rif.sub   = sub_r;
    assign rif.wdata = wdata_r;

    // open drain: only ever pull low
    assign SERIAL_DATA_LINE_O    = 1'b0;
    assign SERIAL_DATA_LINE_OE_N = ~drive_r;
    assign SUB_MAP_SELECTOR      = map_r;
    assign BUSY                  = (state_r != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence seq_byte_end(dcis_state_t st);
        state_r == st && byte_end && !start_cond && !stop_cond;
    endsequence

    sequence seq_released_idle;
        state_r == ST_IDLE && !drive_r;
    endsequence

    chk_start_enters: assert property (
        start_cond && !stop_cond |=> state_r == ST_DEV && !drive_r && cnt_r == CNT_ZERO)
        else $error("start did not begin address phase");

    chk_stop_idle: assert property (
        stop_cond |=> seq_released_idle)
        else $error("stop did not return to idle");

    chk_own_addr_ack: assert property (
        seq_byte_end(ST_DEV) and shift_r[7:1] == {MAIN_ADDR_BASE[6:1], asel}
        |=> state_r == ST_DACK && drive_r [*2])
        else $error("own main address not acknowledged");

    chk_foreign_idle: assert property (
        seq_byte_end(ST_DEV) and !main_hit and !pp_hit |=> seq_released_idle)
        else $error("foreign address not released");

    chk_pp_closed: assert property (
        seq_byte_end(ST_DEV) and rif.pp_addr == PP_ADDR_OFF and !main_hit
        |=> state_r == ST_IDLE)
        else $error("postproc map answered while unprogrammed");

    chk_bad_sub_nak: assert property (
        seq_byte_end(ST_SUB) and shift_r > top |=> seq_released_idle)
        else $error("invalid subaddress acknowledged");

    chk_wr_commit: assert property (
        seq_byte_end(ST_WDAT) and !ovf_r
        |=> rif.wr_en && drive_r && rif.wdata == $past(shift_r) ##1 !rif.wr_en)
        else $error("written byte not stored on acknowledge");

    chk_wr_overrun: assert property (
        seq_byte_end(ST_WDAT) and ovf_r |=> !rif.wr_en && state_r == ST_IDLE)
        else $error("overrun write not refused");

    chk_sub_advance: assert property (
        state_r == ST_WACK && scl_fall && !stop_cond && !start_cond && sub_r != top
        |=> sub_r == $past(sub_r) + 8'h01)
        else $error("subaddress did not advance");

    chk_rd_top_hold: assert property (
        seq_byte_end(ST_RDAT) and sub_r == top |=> sub_r == $past(sub_r))
        else $error("read moved past highest subaddress");
endmodule
`default_nettype wire

/* dv/dcis_host_model.sv */
// model of the host serial master: clock and open-drain data drive
`timescale 1ns/1ps
`default_nettype none
module dcis_host_model (
    input  wire logic clk,      // bench system clock
    input  wire logic sda_wire, // resolved data wire
    output logic      scl,      // serial clock, high outside frames
    output logic      sda_drv   // master data drive, 1 = released
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // one quarter of the 80 ns serial period, launched just after an edge
    task automatic q();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // one start per clock high period, also as a repeated start
    task automatic start();
        sda_drv = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl = 1'b0;
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
    endtask

    // data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_drv = b;
        q();
        scl = 1'b1;
        q();
        r = sda_wire;
        q();
        scl = 1'b0;
    endtask

    // direction bit travels as bit 0 of the address byte
    task automatic wbyte(input logic [7:0] val, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(val[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // last byte wanted: leave the line high on the ninth pulse
    task automatic rbyte(input logic ack_it, output logic [7:0] val);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            val = {val[6:0], r};
        end
        bit_io(~ack_it, r);
    endtask

    // broken-off byte, to provoke an out-of-sequence stop
    task automatic partial(input logic [7:0] val, input int n);
        logic r;
        for (int i = 7; i > 7 - n; i--) begin
            bit_io(val[i], r);
        end
    endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench of the serial control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcis_pkg::*;
    logic       sys_clk;
    logic       rst_n;
    logic       asel;
    logic       scl;
    logic       sda_drv;
    logic       sda_o;
    logic       sda_oe_n;
    logic       busy;
    wire logic  sda_w;
    dcis_map_t  map_sel;
    logic       a;
    logic [7:0] v;
    int         fail_count = 0;
    int         checks = 0;

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // pull-up wire, either party may pull low
    assign sda_w = sda_drv & ((sda_oe_n === 1'b0) ? sda_o : 1'b1);

    dcis_i2c_slave dcis_i2c_slave_i (
        .SYS_CLK               (sys_clk),
        .RST_N                 (rst_n),
        .SERIAL_CLOCK_LINE     (scl),
        .SERIAL_DATA_LINE_I    (sda_w),
        .SERIAL_DATA_LINE_O    (sda_o),
        .SERIAL_DATA_LINE_OE_N (sda_oe_n),
        .ADDRESS_SELECT_PIN    (asel),
        .SUB_MAP_SELECTOR      (map_sel),
        .BUSY                  (busy)
    );

    dcis_host_model dcis_host_model_i (
        .clk      (sys_clk),
        .sda_wire (sda_w),
        .scl      (scl),
        .sda_drv  (sda_drv)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] b, input logic exp_ack);
        dcis_host_model_i.wbyte(b, a);
        chk({7'h00, a}, {7'h00, exp_ack}, "acknowledge");
    endtask

    task automatic rb(input logic ack_it, input logic [7:0] exp);
        dcis_host_model_i.rbyte(ack_it, v);
        chk(v, exp, "read data");
    endtask

    // detected events lag the pins by two clocks
    task automatic idle_chk();
        repeat (6) @(posedge sys_clk);
        #1;
        chk({7'h00, busy}, 8'h00, "busy after release");
    endtask

    task automatic wreg(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d);
        dcis_host_model_i.start();
        wb(dev, 1'b1);
        wb(sub, 1'b1);
        wb(d, 1'b1);
        dcis_host_model_i.stop();
    endtask

    task automatic rreg(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] exp);
        dcis_host_model_i.start();
        wb(dev, 1'b1);
        wb(sub, 1'b1);
        dcis_host_model_i.start();
        wb(dev | 8'h01, 1'b1);
        rb(1'b0, exp);
        dcis_host_model_i.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // about 8k clocks of traffic expected; a hang stops well short of the run budget
    initial begin
        #300000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        asel = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge sys_clk);
        chk({6'h00, map_sel}, 8'h00, "map after reset");
        rreg(8'h40, SUBMAP_REG, 8'h00);
        rreg(8'h40, PP_ADDR_REG, 8'h00);
        $display("test reset values done");
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'h10, 1'b1);
        wb(8'hA5, 1'b1);
        wb(8'h5A, 1'b1);
        dcis_host_model_i.stop();
        rreg(8'h40, 8'h11, 8'h5A);
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'h10, 1'b1);
        dcis_host_model_i.start();
        wb(8'h41, 1'b1);
        rb(1'b1, 8'hA5);
        rb(1'b0, 8'h5A);
        dcis_host_model_i.stop();
        $display("test write and read done");
        dcis_host_model_i.start();
        wb(8'h42, 1'b0);
        idle_chk();
        dcis_host_model_i.stop();
        @(posedge sys_clk) #1 asel = 1'b1;
        wreg(8'h42, 8'h12, 8'h3C);
        rreg(8'h42, 8'h12, 8'h3C);
        dcis_host_model_i.start();
        wb(8'h40, 1'b0);
        dcis_host_model_i.stop();
        @(posedge sys_clk) #1 asel = 1'b0;
        $display("test address select done");
        for (int k = 1; k < 3; k++) begin
            wreg(8'h40, SUBMAP_REG, 8'(k << 5));
            dcis_host_model_i.start();
            wb(8'h40, 1'b1);
            chk({6'h00, map_sel}, 8'(k), "selected map");
            wb((k == 1 ? TOP_INTVBI : TOP_USER2) + 8'h01, 1'b0);
            idle_chk();
            dcis_host_model_i.stop();
            wreg(8'h40, SUBMAP_REG, 8'h00);
            rreg(8'h40, 8'h10, 8'hA5);
        end
        // unused selector code 11 must fall back to the user map
        wreg(8'h40, SUBMAP_REG, 8'h60);
        rreg(8'h40, 8'h10, 8'hA5);
        chk({6'h00, map_sel}, {6'h00, MAP_USER}, "reserved selector");
        wreg(8'h40, SUBMAP_REG, 8'h00);
        $display("test sub maps done");
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'hFE, 1'b1);
        wb(8'hB4, 1'b1);
        wb(8'hC3, 1'b1);
        wb(8'h99, 1'b0);
        idle_chk();
        dcis_host_model_i.stop();
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'hFE, 1'b1);
        dcis_host_model_i.start();
        wb(8'h41, 1'b1);
        rb(1'b1, 8'hB4);
        rb(1'b1, 8'hC3);
        rb(1'b1, 8'hC3);
        rb(1'b0, 8'hC3);
        dcis_host_model_i.stop();
        $display("test top subaddress done");
        dcis_host_model_i.start();
        wb(8'h00, 1'b0);
        dcis_host_model_i.stop();
        wreg(8'h40, PP_ADDR_REG, 8'h84);
        @(posedge sys_clk) #1 asel = 1'b1;
        wreg(8'h42, SUBMAP_REG, 8'h20);
        wreg(8'h84, 8'h05, 8'h6B);
        dcis_host_model_i.start();
        wb(8'h84, 1'b1);
        chk({6'h00, map_sel}, {6'h00, MAP_PP}, "postproc map");
        wb(8'h05, 1'b1);
        dcis_host_model_i.start();
        wb(8'h85, 1'b1);
        rb(1'b0, 8'h6B);
        dcis_host_model_i.stop();
        wreg(8'h42, SUBMAP_REG, 8'h00);
        @(posedge sys_clk) #1 asel = 1'b0;
        $display("test postproc map done");
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'h20, 1'b1);
        wb(8'h11, 1'b1);
        wb(8'h22, 1'b1);
        dcis_host_model_i.stop();
        dcis_host_model_i.start();
        wb(8'h40, 1'b1);
        wb(8'h20, 1'b1);
        wb(8'h77, 1'b1);
        dcis_host_model_i.partial(8'hFF, 4);
        dcis_host_model_i.stop();
        idle_chk();
        rreg(8'h40, 8'h20, 8'h77);
        rreg(8'h40, 8'h21, 8'h22);
        $display("test abort done");
        complete_run();
    end
endmodule
`default_nettype wire
